// File: rtl/utfm_pkg.sv
// Package of offsets, field positions and reset values for the flag monitor
package utfm_pkg;
	localparam logic [7:0] UTFM_OFF_CONTROL   = 8'h04;
	localparam logic [7:0] UTFM_OFF_DEV_ADDR  = 8'h08;
	localparam logic [7:0] UTFM_OFF_FLAGS     = 8'h1C;
	localparam logic [7:0] UTFM_OFF_HOLD      = 8'h20;
	localparam logic [7:0] UTFM_OFF_MASKS     = 8'h24;
	localparam logic [7:0] UTFM_OFF_FRAME     = 8'h28;
	localparam logic [7:0] UTFM_OFF_PID       = 8'h2C;
	localparam logic [7:0] UTFM_OFF_ENDPOINT  = 8'h30;
	localparam logic [7:0] UTFM_OFF_EP_MARK   = 8'h34;
	localparam logic [7:0] UTFM_OFF_OTG_MASK  = 8'h38;
	localparam logic [7:0] UTFM_OFF_PWRSIG    = 8'h3C;

	localparam int UTFM_NFLAGS    = 7;
	localparam int UTFM_BIT_TOKEN = 6;
	localparam int UTFM_BIT_SE0   = 5;
	localparam int UTFM_BIT_K     = 4;
	localparam int UTFM_BIT_J     = 3;
	localparam int UTFM_BIT_CRC16 = 2;
	localparam int UTFM_BIT_RXACT = 1;
	localparam int UTFM_BIT_RXERR = 0;
	localparam int UTFM_BIT_DECODE_EN = 2;
	localparam int UTFM_BIT_EP_VALID  = 4;
	localparam int UTFM_PWRSIG_W      = 9;

	localparam logic [1:0] UTFM_LS_SE0 = 2'h0;
	localparam logic [1:0] UTFM_LS_J   = 2'h1;
	localparam logic [1:0] UTFM_LS_K   = 2'h2;

	localparam logic [4:0] UTFM_EP_MARK_OR = 5'h10;
	localparam logic [31:0] UTFM_RESET_ZERO = 32'h0000_0000;
endpackage : utfm_pkg

// File: rtl/utfm_monitor.sv
// Line and error flag monitor with port masks, frame count and token capture
//
// Contract
// - Flag 6 sets on a token with good CRC5, PID check and address match.
// - Flag 5 sets when decoded line state is SE0.
// - Flag 4 sets when decoded line state is K.
// - Flag 3 sets when decoded line state is J.
// - Flag 2 sets when a data packet fails CRC16.
// - Flag 1 follows the RxActive input level.
// - Flag 0 follows the RxError input level.
// - Non-held flags 6:2 clear when the next packet arrives.
// - Hold bits 6:0 keep a flag set until software writes 1.
// - Non-held flags 1:0 are overwritten by later condition changes.
// - Flag port a is OR of flags selected by mask bits 7:0.
// - Flag port b is OR of flags selected by mask bits 15:8.
// - Flag port c is OR of flags selected by mask bits 23:16.
// - Flag port d is OR of flags selected by mask bits 31:24.
// - Readable, writable 11-bit frame counter, high 10:8, low 7:0.
// - Last received 4-bit PID kept in read-only bits 3:0.
// - Endpoint of last token that sets flag 6 (good checks, address match) copied to read-only bits 3:0.
// - Bit 4 shows the captured endpoint field holds a valid value.
// - Per-endpoint mark bits 15:0; marked endpoint presented ORed with 0x10.
// - Tokens compared with 7-bit programmable address, zero after reset.
// - Line state decoded only while control bit 2 is set.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module utfm_monitor
	import utfm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	// Transceiver status
	input  wire logic [1:0]  line_state,
	input  wire logic        rx_active,
	input  wire logic        rx_error,
	// Packet decoder events
	input  wire logic        pkt_start,
	input  wire logic        pid_valid,
	input  wire logic [3:0]  pid_value,
	input  wire logic        token_valid,
	input  wire logic        token_crc5_ok,
	input  wire logic        token_pid_ok,
	input  wire logic [6:0]  token_addr,
	input  wire logic [3:0]  token_endp,
	input  wire logic        data_crc16_bad,
	input  wire logic        sof_valid,
	input  wire logic [10:0] sof_number,
	// Flag port outputs
	output var  logic        flag_port_a,
	output var  logic        flag_port_b,
	output var  logic        flag_port_c,
	output var  logic        flag_port_d,
	// Endpoint presented on the receive port
	output var  logic [4:0]  rx_endpoint
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]             control_q;
	logic [6:0]             dev_addr_q;
	logic [UTFM_NFLAGS-1:0] flags_q;
	logic [UTFM_NFLAGS-1:0] flags_d;
	logic [UTFM_NFLAGS-1:0] flag_hold_bits_q;
	logic [31:0]            masks_q;
	logic [10:0]            frame_count_q;
	logic [3:0]             last_pid_field_q;
	logic [3:0]             last_endpoint_field_q;
	logic                   endpoint_valid_bit_q;
	logic [15:0]            ep_mark_q;
	logic [31:0]            otg_status_mask_bits_q;
	logic [UTFM_PWRSIG_W-1:0] power_signal_q;
	logic [UTFM_NFLAGS-1:0] event_set;
	logic [UTFM_NFLAGS-1:0] level_val;
	logic [UTFM_NFLAGS-1:0] is_level;
	logic                   token_hit;
	logic                   decode_en;

	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = reg_wr && (reg_addr == off);
	endfunction : wr_hit

	////////////////////////////////////////////////////////////////////////
	// Condition decode

	assign decode_en = control_q[UTFM_BIT_DECODE_EN];
	assign token_hit = token_valid && token_crc5_ok && token_pid_ok
		&& (token_addr == dev_addr_q);

	always_comb begin
		event_set = '0;
		level_val = '0;
		is_level  = '0;
		event_set[UTFM_BIT_TOKEN] = token_hit;
		event_set[UTFM_BIT_SE0] = decode_en && (line_state == UTFM_LS_SE0);
		event_set[UTFM_BIT_K] = decode_en && (line_state == UTFM_LS_K);
		event_set[UTFM_BIT_J] = decode_en && (line_state == UTFM_LS_J);
		event_set[UTFM_BIT_CRC16] = data_crc16_bad;
		is_level[UTFM_BIT_RXACT]  = 1'b1;
		level_val[UTFM_BIT_RXACT] = rx_active;
		is_level[UTFM_BIT_RXERR]  = 1'b1;
		level_val[UTFM_BIT_RXERR] = rx_error;
		event_set[UTFM_BIT_RXACT] = rx_active;
		event_set[UTFM_BIT_RXERR] = rx_error;
	end

	////////////////////////////////////////////////////////////////////////
	// Flag update, one bit at a time

	genvar gi;
	generate
		for (gi = 0; gi < UTFM_NFLAGS; gi++) begin : g_flag
			always_comb begin
				flags_d[gi] = flags_q[gi];
				if (flag_hold_bits_q[gi]) begin
					if (wr_hit(UTFM_OFF_FLAGS) && reg_wdata[gi])
						flags_d[gi] = 1'b0;
					if (event_set[gi])
						flags_d[gi] = 1'b1;
				end else begin
					if (pkt_start)
						flags_d[gi] = 1'b0;
					if (wr_hit(UTFM_OFF_FLAGS) && reg_wdata[gi])
						flags_d[gi] = 1'b0;
					if (is_level[gi])
						flags_d[gi] = level_val[gi];
					else if (event_set[gi])
						flags_d[gi] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			flags_q <= '0;
		else
			flags_q <= flags_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			control_q              <= '0;
			dev_addr_q             <= '0;
			flag_hold_bits_q       <= '0;
			masks_q                <= UTFM_RESET_ZERO;
			ep_mark_q              <= '0;
			otg_status_mask_bits_q <= UTFM_RESET_ZERO;
			power_signal_q         <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				UTFM_OFF_CONTROL:  control_q <= reg_wdata[7:0];
				UTFM_OFF_DEV_ADDR: dev_addr_q <= reg_wdata[6:0];
				UTFM_OFF_HOLD:     flag_hold_bits_q <= reg_wdata[6:0];
				UTFM_OFF_MASKS:    masks_q <= reg_wdata;
				UTFM_OFF_EP_MARK:  ep_mark_q <= reg_wdata[15:0];
				UTFM_OFF_OTG_MASK: otg_status_mask_bits_q <= reg_wdata;
				UTFM_OFF_PWRSIG:   power_signal_q <= reg_wdata[8:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame counter

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			frame_count_q <= '0;
		else if (sof_valid)
			frame_count_q <= sof_number;
		else if (wr_hit(UTFM_OFF_FRAME))
			frame_count_q <= reg_wdata[10:0];
	end

	////////////////////////////////////////////////////////////////////////
	// PID and endpoint capture

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			last_pid_field_q <= '0;
		else if (pid_valid)
			last_pid_field_q <= pid_value;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_endpoint_field_q <= '0;
			endpoint_valid_bit_q  <= 1'b0;
			rx_endpoint           <= '0;
		end else if (token_hit) begin
			last_endpoint_field_q <= token_endp;
			endpoint_valid_bit_q  <= 1'b1;
			if (ep_mark_q[token_endp])
				rx_endpoint <= {1'b0, token_endp} | UTFM_EP_MARK_OR;
			else
				rx_endpoint <= {1'b0, token_endp};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag ports

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_port_a <= 1'b0;
			flag_port_b <= 1'b0;
			flag_port_c <= 1'b0;
			flag_port_d <= 1'b0;
		end else begin
			flag_port_a <= |(flags_d & masks_q[6:0]);
			flag_port_b <= |(flags_d & masks_q[14:8]);
			flag_port_c <= |(flags_d & masks_q[22:16]);
			flag_port_d <= |(flags_d & masks_q[30:24]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (reg_rd) begin
			case (reg_addr)
				UTFM_OFF_CONTROL:  reg_rdata <= {24'h000000, control_q};
				UTFM_OFF_DEV_ADDR: reg_rdata <= {25'h0, dev_addr_q};
				UTFM_OFF_FLAGS:    reg_rdata <= {25'h0, flags_q};
				UTFM_OFF_HOLD:     reg_rdata <= {25'h0, flag_hold_bits_q};
				UTFM_OFF_MASKS:    reg_rdata <= masks_q;
				UTFM_OFF_FRAME:    reg_rdata <= {21'h0, frame_count_q};
				UTFM_OFF_PID:      reg_rdata <= {28'h0, last_pid_field_q};
				UTFM_OFF_ENDPOINT: reg_rdata <= {27'h0,
					endpoint_valid_bit_q, last_endpoint_field_q};
				UTFM_OFF_EP_MARK:  reg_rdata <= {16'h0000, ep_mark_q};
				UTFM_OFF_OTG_MASK: reg_rdata <= otg_status_mask_bits_q;
				UTFM_OFF_PWRSIG:   reg_rdata <= {23'h0, power_signal_q};
				default:           reg_rdata <= '0;
			endcase
		end else
			reg_rdata <= '0;
	end

endmodule : utfm_monitor

`default_nettype wire

// File: tb/utfm_chk_monitor.sv
// Port checker for the flag monitor
`timescale 1ns/10ps
`default_nettype none
module utfm_chk_monitor
	import utfm_pkg::*;
(
	// Clock, reset and register port
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Token inputs and endpoint output
	input wire logic        token_valid,
	input wire logic        token_crc5_ok,
	input wire logic        token_pid_ok,
	input wire logic [3:0]  token_endp,
	input wire logic [4:0]  rx_endpoint
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_flag_resv: assert property (s_rd(UTFM_OFF_FLAGS) |=>
		reg_rdata[31:7] == 25'h0) else $error("flag reserved bits set");
	a_frame_resv: assert property (s_rd(UTFM_OFF_FRAME) |=>
		reg_rdata[31:11] == 21'h0) else $error("frame reserved bits set");
	a_pid_resv: assert property (s_rd(UTFM_OFF_PID) |=>
		reg_rdata[31:4] == 28'h0) else $error("pid reserved bits set");
	a_ep_resv: assert property (s_rd(UTFM_OFF_ENDPOINT) |=>
		reg_rdata[31:5] == 27'h0) else $error("endpoint reserved bits set");
	a_mark_resv: assert property (s_rd(UTFM_OFF_EP_MARK) |=>
		reg_rdata[31:16] == 16'h0) else $error("mark reserved bits set");
	a_ep_cause: assert property ($changed(rx_endpoint[3:0]) |->
		$past(token_valid) && $past(token_crc5_ok) && $past(token_pid_ok))
		else $error("endpoint changed without good token");
	a_ep_copy: assert property ($changed(rx_endpoint[3:0]) |->
		rx_endpoint[3:0] == $past(token_endp))
		else $error("endpoint not copied from token");
endmodule : utfm_chk_monitor
`default_nettype wire

// File: tb/utfm_xcvr_model.sv
// Transceiver stand-in driving line state and receive levels
`timescale 1ns/10ps
`default_nettype none
module utfm_xcvr_model
	import utfm_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Receive status
	output var  logic [1:0] line_state,
	output var  logic       rx_active,
	output var  logic       rx_error
);
	initial begin
		line_state = UTFM_LS_J;
		rx_active  = 1'b0;
		rx_error   = 1'b0;
	end
	task automatic drive(input logic [1:0] ls, input logic ac, er);
		@(posedge clk);
		line_state <= ls;
		rx_active  <= ac;
		rx_error   <= er;
	endtask : drive
endmodule : utfm_xcvr_model
`default_nettype wire

// File: tb/usb_token_flag_monitor_test.sv
// Self-checking bench for the flag monitor
`timescale 1ns/10ps
`default_nettype none
module usb_token_flag_monitor_test;
	import utfm_pkg::*;
	logic        clk, arst_n, reg_wr, reg_rd, ac, er, pa, pb, pc, pd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [4:0]  evt, rx_ep;
	logic [1:0]  tok_ok, ls;
	logic [10:0] val;
	int          err_count, num_checks;
	logic [7:0]  ta[5] = '{8'h20, 8'h24, 8'h28, 8'h34, 8'h2C};
	logic [31:0] te[5] = '{32'h7F, '1, 32'h7FF, 32'hFFFF, 32'h0};
	logic [1:0]  tl[3] = '{UTFM_LS_SE0, UTFM_LS_J, UTFM_LS_K};
	logic [31:0] tf[3] = '{32'h20, 32'h08, 32'h10};
	utfm_xcvr_model xcvr (.clk, .line_state(ls), .rx_active(ac),
		.rx_error(er));
	utfm_monitor dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .line_state(ls), .rx_active(ac), .rx_error(er),
		.pkt_start(evt[0]), .pid_valid(evt[1]), .pid_value(val[3:0]),
		.token_valid(evt[4]), .token_crc5_ok(tok_ok[0]),
		.token_pid_ok(tok_ok[1]), .token_addr(val[10:4]),
		.token_endp(val[3:0]), .data_crc16_bad(evt[2]), .sof_valid(evt[3]),
		.sof_number(val), .flag_port_a(pa), .flag_port_b(pb),
		.flag_port_c(pc), .flag_port_d(pd), .rx_endpoint(rx_ep));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask : rd
	task automatic pulse(input logic [6:0] m, input logic [10:0] v);
		@(posedge clk);
		evt    <= m[4:0];
		tok_ok <= m[6:5];
		val    <= v;
		@(posedge clk);
		evt <= 5'h0;
		#1;
	endtask : pulse
	task automatic pt(input logic [8:0] e);
		chk({23'h0, rx_ep, pd, pc, pb, pa}, {23'h0, e});
	endtask : pt
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		#20000;
		err_count++;
		results;
	end
	initial begin
		{reg_wr, reg_rd, evt, tok_ok, reg_addr, reg_wdata, val} = '0;
		err_count = 0;
		num_checks = 0;
		arst_n = 1'b0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 8'h1C; a <= 8'h44; a += 4) rd(8'(a), '1, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(ta[i], '1);
			rd(ta[i], '1, te[i]);
		end
		$display("test access done");
		wr(UTFM_OFF_DEV_ADDR, 32'h5);
		wr(UTFM_OFF_MASKS, 32'h0401_0240);
		wr(UTFM_OFF_HOLD, 32'h0);
		wr(UTFM_OFF_EP_MARK, 32'h200);
		pulse(7'h70, 11'h053);
		pt(9'h031);
		rd(UTFM_OFF_ENDPOINT, '1, 32'h13);
		pulse(7'h50, 11'h057);
		pulse(7'h30, 11'h057);
		pulse(7'h70, 11'h067);
		pt(9'h031);
		pulse(7'h70, 11'h059);
		pt(9'h191);
		pulse(7'h01, 11'h0);
		pt(9'h190);
		$display("test token done");
		wr(UTFM_OFF_HOLD, 32'h40);
		pulse(7'h70, 11'h059);
		pulse(7'h01, 11'h0);
		pt(9'h191);
		wr(UTFM_OFF_FLAGS, 32'h0);
		rd(UTFM_OFF_FLAGS, '1, 32'h40);
		wr(UTFM_OFF_FLAGS, 32'h40);
		rd(UTFM_OFF_FLAGS, '1, 32'h0);
		wr(UTFM_OFF_HOLD, 32'h0);
		pulse(7'h04, 11'h0);
		pt(9'h198);
		pulse(7'h01, 11'h0);
		xcvr.drive(UTFM_LS_J, 1'b1, 1'b0);
		@(posedge clk) #1 pt(9'h192);
		xcvr.drive(UTFM_LS_J, 1'b0, 1'b1);
		@(posedge clk) #1 pt(9'h194);
		xcvr.drive(UTFM_LS_K, 1'b0, 1'b0);
		pulse(7'h01, 11'h0);
		rd(UTFM_OFF_FLAGS, '1, 32'h0);
		wr(UTFM_OFF_CONTROL, 32'h4);
		for (int i = 0; i < 3; i++) begin
			xcvr.drive(tl[i], 1'b0, 1'b0);
			pulse(7'h01, 11'h0);
			rd(UTFM_OFF_FLAGS, 32'h38, tf[i]);
		end
		$display("test flags done");
		pulse(7'h08, 11'h5A3);
		rd(UTFM_OFF_FRAME, '1, 32'h5A3);
		pulse(7'h02, 11'h00A);
		rd(UTFM_OFF_PID, '1, 32'hA);
		pulse(7'h02, 11'h003);
		rd(UTFM_OFF_PID, '1, 32'h3);
		$display("test capture done");
		results;
	end
endmodule : usb_token_flag_monitor_test
bind utfm_monitor utfm_chk_monitor u_chk (.clk, .arst_n, .reg_addr, .reg_rd,
	.reg_rdata, .token_valid, .token_crc5_ok, .token_pid_ok, .token_endp,
	.rx_endpoint);
`default_nettype wire
